/* File: src/evsps_top.sv */
// Pilot state sequencer with ground-fault self-test and AHB-Lite registers
// Contract
// - State is evaluated only on a once-per-second tick counted from metering samples.
// - Self-test state sets the expect flag and pulses the test coil once.
// - Detector firing while expected records a passed test, not a trip fault.
// - Expect state faults on a missed test pulse, else moves to pass state.
// - Pass state does no pilot signalling and then moves to state A.
// - Entering state A drives the pilot line steadily high.
// - State A leaves only to B or fault, to B when the vehicle connect drop is reported.
// - Any other unexpected pilot level in state A gives a pilot fault.
// - Entering state B switches the pilot line to PWM.
// - State B goes to C on ready, A on unplug, fault on pilot fault.
// - Entering state C closes the charge relay.
// - State C goes to B, A, D or fault according to the pilot level.
// - All four faults are critical, latched, and cleared only by restart.
// - Pilot levels are sampled once per tick, so reaction takes up to a second.
`timescale 1ns/1ps
module evsps_top
   import evsps_pkg::*;
#(
   parameter logic [TICK_W-1:0] TICK_SAMPLES = TICK_CFG_RST
)(
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        ARST_N,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output wire logic [31:0] HRDATA,
   output wire logic        HREADYOUT,
   output wire logic        HRESP,
   // Metering and sensing
   input  wire logic        SAMPLE_STB,
   input  wire logic [2:0]  PILOT_LEVEL,
   input  wire logic        GF_DETECT,
   input  wire logic        RELAY_FB,
   // Actuators
   output wire logic        PILOT_OUT,
   output wire logic        PILOT_HIGH,
   output wire logic        RELAY_CLOSE,
   output wire logic        GF_TEST_COIL,
   // Interrupt
   output wire logic        IRQ
);

   // Synchronised copy of the reset
   logic [1:0]  rst_pipe;
   logic        rst_n;

   // Whole block state and its next value
   evsps_regs_t s;
   evsps_regs_t next_s;

   // Interrupt set and clear strobes of this cycle
   logic [IRQ_W-1:0] ev_set;
   logic [IRQ_W-1:0] ev_clr;

   // Pilot PWM compare, high for the first duty cycles of a period
   logic        pwm_level;

   // Reset release through two flops; only the second is used
   // Assertion is immediate; release waits two edges against metastability
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // Register readback; unmapped offsets read as zero
   // Captured at the address phase, so the bus never needs a wait state
   function automatic logic [31:0] read_mux(input logic [7:0] a, input evsps_regs_t r);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         REG_TICK_CFG:   v[TICK_W-1:0] = r.tick_cfg;
         REG_PWM_DUTY:   v[PWM_W-1:0] = r.duty;
         REG_STATE:      v[7:0] = {r.pilot_out, r.pilot_high, r.relay, r.gf_expect,
                                   r.st};
         REG_FAULT:      v[FAULT_W-1:0] = r.faults;
         REG_IRQ_STATUS: v[IRQ_W-1:0] = r.irq_stat;
         REG_IRQ_MASK:   v[IRQ_W-1:0] = r.irq_mask;
         default:        v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Next-state logic for the whole block
   always_comb begin
      // Pulses default low; every other register holds
      next_s = s;
      next_s.tick = 1'b0;
      next_s.coil = 1'b0;
      next_s.ready = 1'b1;

      // No events unless raised below
      ev_set = '0;
      ev_clr = '0;

      // Write data phase: commit the captured address
      // STATE and FAULT are read only and fall to the default
      if (s.wr_pend) begin
         unique case (s.wr_addr)
            REG_TICK_CFG:   next_s.tick_cfg = HWDATA[TICK_W-1:0];
            REG_PWM_DUTY:   next_s.duty = HWDATA[PWM_W-1:0];
            REG_IRQ_STATUS: ev_clr = HWDATA[IRQ_W-1:0];
            REG_IRQ_MASK:   next_s.irq_mask = HWDATA[IRQ_W-1:0];
            default:        next_s.wr_pend = 1'b0;
         endcase
      end

      // Address phase: zero wait states, read data captured now
      // A read meeting a write data phase still sees the old value
      next_s.wr_pend = 1'b0;
      if (HSEL && HTRANS[1] && HREADY) begin
         next_s.wr_pend = HWRITE;
         next_s.wr_addr = HADDR[7:0];
         if (!HWRITE) begin
            next_s.rd = read_mux(HADDR[7:0], s);
         end
      end

      // Once-per-second tick from the metering sample count
      // A count of zero wraps the compare to the maximum, giving a tick every 65536 samples
      if (SAMPLE_STB) begin
         if (s.tick_cnt >= s.tick_cfg - 16'h0001) begin
            next_s.tick_cnt = '0;
            next_s.tick = 1'b1;
         end else begin
            next_s.tick_cnt = s.tick_cnt + 16'h0001;
         end
      end

      // Free-running pilot PWM period counter
      // Period is fixed; only the high time is programmable
      if (s.pwm_cnt >= PWM_PERIOD - 17'h00001) begin
         next_s.pwm_cnt = '0;
      end else begin
         next_s.pwm_cnt = s.pwm_cnt + 17'h00001;
      end

      // Detector: expected pulse is a pass, anything else is a trip
      // Each high cycle counts, so a stuck detector trips at once
      if (GF_DETECT) begin
         if (s.gf_expect) begin
            next_s.gf_seen = 1'b1;
         end else begin
            next_s.faults[FLT_GF_TRIP] = 1'b1;
         end
      end

      // Relay welded: feedback closed while it has been commanded open
      // Looked at on the tick only, so contact bounce after opening is ignored
      if (s.tick && !s.relay && RELAY_FB) begin
         next_s.faults[FLT_RELAY] = 1'b1;
      end

      // Sequencer moves only on the tick, sampling the pilot level then
      // Up to a second of latency, which the pilot handshake tolerates
      if (s.tick) begin
         unique case (s.st)
            ST_START: begin
               next_s.st = ST_GF_SELFTEST;
            end
            ST_GF_SELFTEST: begin
               next_s.gf_expect = 1'b1;
               next_s.gf_seen = 1'b0;
               next_s.coil = 1'b1;
               next_s.st = ST_GF_EXPECT;
            end
            ST_GF_EXPECT: begin
               next_s.gf_expect = 1'b0;
               // A detection in this very cycle still counts as seen
               if (!next_s.gf_seen) begin
                  next_s.faults[FLT_GF_CHECK] = 1'b1;
               end else begin
                  next_s.st = ST_GF_PASS;
                  ev_set[EV_GF_PASS] = 1'b1;
               end
            end
            ST_GF_PASS: begin
               next_s.st = ST_A;
            end
            ST_A: begin
               if (PILOT_LEVEL == PLV_B) begin
                  next_s.st = ST_B;
               end else if (PILOT_LEVEL != PLV_A) begin
                  next_s.faults[FLT_PILOT] = 1'b1;
               end
            end
            ST_B: begin
               if (PILOT_LEVEL == PLV_C) begin
                  next_s.st = ST_C;
               end else if (PILOT_LEVEL == PLV_A) begin
                  next_s.st = ST_A;
               end else if (PILOT_LEVEL != PLV_B && PILOT_LEVEL != PLV_D) begin
                  next_s.faults[FLT_PILOT] = 1'b1;
               end
            end
            ST_C, ST_D: begin
               unique case (PILOT_LEVEL)
                  PLV_A:   next_s.st = ST_A;
                  PLV_B:   next_s.st = ST_B;
                  PLV_C:   next_s.st = ST_C;
                  PLV_D:   next_s.st = ST_D;
                  default: next_s.faults[FLT_PILOT] = 1'b1;
               endcase
            end
            ST_FAULT: begin
               // Only a restart leaves this state
               next_s.st = ST_FAULT;
            end
            default: next_s.st = ST_FAULT;
         endcase
         // Any latched fault wins over the normal step
         // Trip faults raised between ticks wait here; relay faults are raised on the tick itself
         if (next_s.faults != '0) begin
            next_s.st = ST_FAULT;
            next_s.gf_expect = 1'b0;
         end
      end

      // Outputs follow the state being entered
      pwm_level = (s.pwm_cnt < s.duty);
      unique case (next_s.st)
         ST_A: begin
            next_s.pilot_high = 1'b1;
            next_s.pilot_out = 1'b1;
         end
         ST_B, ST_C, ST_D: begin
            next_s.pilot_high = 1'b0;
            next_s.pilot_out = pwm_level;
         end
         default: begin
            // Start, self-test and fault hold the line low and still
            next_s.pilot_high = 1'b0;
            next_s.pilot_out = 1'b0;
         end
      endcase
      // Relay only closed in C; D is kept open since venting is not handled
      // Leaving C for any state opens it through the same compare
      next_s.relay = (next_s.st == ST_C);

      // Sticky interrupt events; a new event beats a same-cycle clear
      if (s.tick && next_s.st != s.st) begin
         ev_set[EV_STATE] = 1'b1;
      end
      if (next_s.st == ST_FAULT && s.st != ST_FAULT) begin
         ev_set[EV_FAULT] = 1'b1;
      end
      next_s.irq_stat = (s.irq_stat & ~ev_clr) | ev_set;

      // Level interrupt from the status and mask being registered
      next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
   end

   // State register; faults survive everything but reset
   // Only the synchronised reset reaches these flops
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s.rd <= 32'h0000_0000;
         s.ready <= 1'b1;
         s.wr_pend <= 1'b0;
         s.wr_addr <= 8'h00;
         s.tick_cnt <= '0;
         s.tick_cfg <= TICK_SAMPLES;
         s.tick <= 1'b0;
         s.pwm_cnt <= '0;
         s.duty <= PWM_DUTY_RST;
         s.st <= ST_START;
         s.gf_expect <= 1'b0;
         s.gf_seen <= 1'b0;
         s.faults <= '0;
         s.relay <= 1'b0;
         s.pilot_out <= 1'b0;
         s.pilot_high <= 1'b0;
         s.coil <= 1'b0;
         s.irq_stat <= '0;
         s.irq_mask <= IRQ_MASK_RST;
         s.irq <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // Port drive straight from the state flops, except HRESP which is tied off
   assign HRDATA = s.rd;
   assign HREADYOUT = s.ready;
   assign HRESP = 1'b0; // Always OKAY

   // Actuators and interrupt
   assign PILOT_OUT = s.pilot_out;
   assign PILOT_HIGH = s.pilot_high;
   assign RELAY_CLOSE = s.relay;
   assign GF_TEST_COIL = s.coil;
   assign IRQ = s.irq;

endmodule

/* File: src/evsps_pkg.sv */
// Shared constants and types for the pilot state sequencer
package evsps_pkg;

   // Register byte offsets on the AHB-Lite port
   localparam logic [7:0] REG_TICK_CFG   = 8'h00;
   localparam logic [7:0] REG_PWM_DUTY   = 8'h04;
   localparam logic [7:0] REG_STATE      = 8'h08;
   localparam logic [7:0] REG_FAULT      = 8'h0C;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK   = 8'h14;

   // Field widths
   localparam int TICK_W  = 16;
   localparam int PWM_W   = 17;
   localparam int FAULT_W = 4;
   localparam int IRQ_W   = 3;

   // Values after reset, and the fixed PWM period
   localparam logic [TICK_W-1:0]  TICK_CFG_RST = 16'h1000;
   localparam logic [PWM_W-1:0]   PWM_PERIOD   = 17'h186A0;
   localparam logic [PWM_W-1:0]   PWM_DUTY_RST = 17'h0C350;
   localparam logic [IRQ_W-1:0]   IRQ_MASK_RST = 3'h0;

   // Fault bit positions
   localparam int FLT_GF_CHECK = 0;
   localparam int FLT_GF_TRIP  = 1;
   localparam int FLT_RELAY    = 2;
   localparam int FLT_PILOT    = 3;

   // Interrupt event bit positions
   localparam int EV_STATE   = 0;
   localparam int EV_FAULT   = 1;
   localparam int EV_GF_PASS = 2;

   // Pilot level codes reported by the pilot_voltage_converter handler
   localparam logic [2:0] PLV_A = 3'h0;
   localparam logic [2:0] PLV_B = 3'h1;
   localparam logic [2:0] PLV_C = 3'h2;
   localparam logic [2:0] PLV_D = 3'h3;

   // Sequencer states
   typedef enum logic [3:0] {
      ST_START,
      ST_GF_SELFTEST,
      ST_GF_EXPECT,
      ST_GF_PASS,
      ST_A,
      ST_B,
      ST_C,
      ST_D,
      ST_FAULT
   } evsps_state_t;

   // Whole module state
   typedef struct packed {
      logic [31:0]        rd;
      logic               ready;
      logic               wr_pend;
      logic [7:0]         wr_addr;
      logic [TICK_W-1:0]  tick_cnt;
      logic [TICK_W-1:0]  tick_cfg;
      logic               tick;
      logic [PWM_W-1:0]   pwm_cnt;
      logic [PWM_W-1:0]   duty;
      evsps_state_t       st;
      logic               gf_expect;
      logic               gf_seen;
      logic [FAULT_W-1:0] faults;
      logic               relay;
      logic               pilot_out;
      logic               pilot_high;
      logic               coil;
      logic [IRQ_W-1:0]   irq_stat;
      logic [IRQ_W-1:0]   irq_mask;
      logic               irq;
   } evsps_regs_t;

endpackage

/* File: testbench/evsps_chk.sv */
// Port checker for the pilot state sequencer
`timescale 1ns/1ps
module evsps_chk
   import evsps_pkg::*;
(
   // Clock and reset
   input wire logic        SYS_CLK,
   input wire logic        ARST_N,
   // Bus
   input wire logic        HSEL,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   // Sequencer
   input wire logic        SAMPLE_STB,
   input wire logic        PILOT_OUT,
   input wire logic        PILOT_HIGH,
   input wire logic        RELAY_CLOSE,
   input wire logic        GF_TEST_COIL
);
   logic [2:0] stb_h;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   // Recent strobes; a move without one means a move off the tick
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) stb_h <= 3'h0;
      else stb_h <= {stb_h[1:0], SAMPLE_STB};
   end
   property p_resp; HRESP == 1'h0; endproperty
   property p_rdy; HREADYOUT; endproperty
   property p_coil; GF_TEST_COIL |=> !GF_TEST_COIL [*8]; endproperty
   property p_coil_tk; $rose(GF_TEST_COIL) |-> |stb_h; endproperty
   property p_rly_tk; $changed(RELAY_CLOSE) |-> |stb_h; endproperty
   property p_ph_tk; $changed(PILOT_HIGH) |-> |stb_h; endproperty
   property p_excl; RELAY_CLOSE |-> !PILOT_HIGH; endproperty
   property p_phigh; PILOT_HIGH |-> PILOT_OUT; endproperty
   property p_safe; GF_TEST_COIL |-> !(PILOT_HIGH || RELAY_CLOSE || PILOT_OUT); endproperty
   property p_hrd; !(HSEL && HTRANS[1] && HREADY && !HWRITE) |=> $stable(HRDATA); endproperty
   a_resp: assert property (p_resp) else $error("bad response");
   a_rdy: assert property (p_rdy) else $error("wait state");
   a_coil: assert property (p_coil) else $error("coil pulse too long");
   a_coil_tk: assert property (p_coil_tk) else $error("coil off tick");
   a_rly_tk: assert property (p_rly_tk) else $error("relay off tick");
   a_ph_tk: assert property (p_ph_tk) else $error("pilot off tick");
   a_excl: assert property (p_excl) else $error("relay outside C");
   a_phigh: assert property (p_phigh) else $error("pilot not high");
   a_safe: assert property (p_safe) else $error("signal in self-test");
   a_hrd: assert property (p_hrd) else $error("read data moved");
   c_rly: cover property ($rose(RELAY_CLOSE));
   c_coil: cover property ($rose(GF_TEST_COIL));
   c_ph: cover property ($fell(PILOT_HIGH));
endmodule
bind evsps_top evsps_chk u_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .HSEL(HSEL),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SAMPLE_STB(SAMPLE_STB), .PILOT_OUT(PILOT_OUT),
   .PILOT_HIGH(PILOT_HIGH), .RELAY_CLOSE(RELAY_CLOSE), .GF_TEST_COIL(GF_TEST_COIL));

/* File: testbench/evsps_vehicle.sv */
// Vehicle on the pilot wire, showing a commanded level code
`timescale 1ns/1ps
module evsps_vehicle (
   // Clock and command
   input  wire logic       clk,
   input  wire logic [2:0] want,
   // Pilot wire
   input  wire logic       pilot_out,
   output logic      [2:0] level
);
   // Resistance change lands one edge after the command
   always_ff @(posedge clk) begin
      level <= want;
   end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the pilot state sequencer
`timescale 1ns/1ps
module tb_top;
   import evsps_pkg::*;
   logic        clk = '0, arst_n = '0, hsel = '0, hwrite = '0, stb = '0, gf = '0;
   logic        rfb = '0, echo = 1'h1, trip = '0, weld = '0;
   logic [1:0]  htrans = '0;
   logic [31:0] haddr = '0, hwdata = '0, q, d;
   logic [2:0]  want = '0, l;
   logic [3:0]  cur;
   wire  [31:0] hrdata;
   wire  [2:0]  lvl;
   wire         rdy, hresp, pout, phigh, rly, coil, irq;
   int          n_fail = 0, tests_run = 0, cyc = 0;
   evsps_top #(.TICK_SAMPLES(16'h0003)) u_evsps_top (.SYS_CLK(clk), .ARST_N(arst_n),
      .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(hresp),
      .SAMPLE_STB(stb), .PILOT_LEVEL(lvl), .GF_DETECT(gf), .RELAY_FB(rfb),
      .PILOT_OUT(pout), .PILOT_HIGH(phigh), .RELAY_CLOSE(rly), .GF_TEST_COIL(coil),
      .IRQ(irq));
   evsps_vehicle u_evsps_vehicle (.clk(clk), .want(want), .pilot_out(pout), .level(lvl));
   initial forever #5 clk = ~clk;
   // Detector answers the coil, relay contact follows its coil, hang guard
   always @(posedge clk) begin
      gf <= (echo & coil) | trip;
      rfb <= rly | weld;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // One single AHB transfer, master waits on ready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge clk);
      while (!rdy) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (!rdy) @(posedge clk);
      q = hrdata;
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk) stb <= 1'h1;
         @(posedge clk) stb <= 1'h0;
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic st(input logic [3:0] e);
      bus(1'h0, REG_STATE, '0);
      chk({25'h0, q[6:0]}, {25'h0, e == 4'h4, e == 4'h6, e == 4'h2, e});
      chk({30'h0, phigh, rly}, {30'h0, e == 4'h4, e == 4'h6});
   endtask
   function automatic logic [3:0] nxt(input logic [3:0] c, input logic [2:0] v);
      if (v > 3'h3) return 4'h8;
      if (c == 4'h4) return (v == 3'h1) ? 4'h5 : (v == 3'h0) ? 4'h4 : 4'h8;
      if (c == 4'h5) return (v == 3'h2) ? 4'h6 : (v == 3'h0) ? 4'h4 : 4'h5;
      return 4'h4 + {1'h0, v};
   endfunction
   task automatic go(input logic [2:0] v);
      @(posedge clk) want <= v;
      tick(2);
      cur = nxt(cur, v);
      st(cur);
   endtask
   task automatic rst();
      @(posedge clk) arst_n <= 1'h0;
      repeat (16) @(posedge clk);
      arst_n <= 1'h1;
      repeat (4) @(posedge clk);
   endtask
   // Main sequence
   initial begin
      void'($urandom(32'hE0960341));
      rst();
      bus(1'h0, REG_TICK_CFG, '0);
      chk(q, 32'h3);
      bus(1'h0, REG_PWM_DUTY, '0);
      chk(q, {15'h0, PWM_DUTY_RST});
      bus(1'h0, 8'h18, '0);
      chk(q, '0);
      bus(1'h1, REG_STATE, 32'h5);
      st(4'h0);
      d = $urandom;
      bus(1'h1, REG_PWM_DUTY, d);
      bus(1'h0, REG_PWM_DUTY, '0);
      chk(q, {15'h0, d[16:0]});
      bus(1'h1, REG_TICK_CFG, 32'h2);
      tick(2);
      st(4'h1);
      chk({31'h0, irq}, '0);
      bus(1'h1, REG_IRQ_MASK, 32'h7);
      tick(2);
      st(4'h2);
      tick(2);
      st(4'h3);
      bus(1'h0, REG_FAULT, '0);
      chk(q, '0);
      tick(2);
      st(4'h4);
      $display("self-test done");
      cur = 4'h4;
      go(3'h1);
      bus(1'h1, REG_PWM_DUTY, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, pout}, '0);
      bus(1'h1, REG_PWM_DUTY, 32'h1FFFF);
      repeat (2) @(posedge clk);
      chk({31'h0, pout}, 32'h1);
      go(3'h2); go(3'h3); go(3'h2); go(3'h1);
      go(3'h0); go(3'h1); go(3'h2); go(3'h0);
      for (int i = 0; i < 12; i++) begin
         l = 3'($urandom % 4);
         if (cur == 4'h4) l[1] = 1'h0;
         go(l);
      end
      go(3'h4 + 3'($urandom % 4));
      bus(1'h0, REG_FAULT, '0);
      chk(q, 32'h8);
      chk({31'h0, pout}, '0);
      @(posedge clk) want <= 3'h0;
      tick(2);
      st(4'h8);
      chk({31'h0, irq}, 32'h1);
      bus(1'h1, REG_IRQ_STATUS, 32'h7);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, '0);
      $display("pilot walk done");
      echo <= 1'h0;
      rst();
      bus(1'h1, REG_TICK_CFG, 32'h1);
      tick(3);
      st(4'h8);
      bus(1'h0, REG_FAULT, '0);
      chk(q, 32'h1);
      $display("missed self-test done");
      rst();
      bus(1'h1, REG_TICK_CFG, 32'h1);
      @(posedge clk) trip <= 1'h1;
      weld <= 1'h1;
      @(posedge clk) trip <= 1'h0;
      tick(1);
      bus(1'h0, REG_FAULT, '0);
      chk(q, 32'h6);
      st(4'h8);
      $display("fault inputs done");
      test_done();
   end
endmodule
